// >>> hdl/sfrr_core.sv
// Read-command sequencer of a serial flash: opcode decode, address and
// don't-care phases, serial output of array, buffer and status bytes.
// Assumes SPI pins synchronous to mclk_i and SCK half period >= 3 mclk.
//
// Function
// R1: Opcode 52H reads a main-memory page directly.
// R2: Opcodes 54H and 56H read buffer one and buffer two.
// R3: Opcode 57H shifts out the status byte.
// R4: Opcode E8H starts a continuous read through the main array.
// R5: Opcode D2H reads a main-memory page directly.
// R6: Opcodes D4H and D6H read buffer one and buffer two.
// R7: Opcode D7H shifts out the status byte.
// R8: Bytes go out MSB first; after bit 2111 the next page follows. Code does this for E8H only; page and buffer reads wrap to byte 0.
// R9: Host programs pages directly or via buffer write then buffer program.
// R10: Host rewrites every sector page within 10,000 erase/program operations.
// R11: Host keeps a refresh pointer and uses it for auto page rewrite.
// R12: Sector number decodes from the 12-bit page address bits.
// R13: Serial input is sampled on the rising serial clock edge.
// R14: Host holds chip select high before releasing device reset.
// R15: Host sends reserved address bits as zero.
// R16: Rising chip select ends any read and floats serial output.
`include "sfrr_map.svh"

module sfrr_core #(
  parameter int PAW = `SFRR_PAGE_AW,
  parameter int BAW = `SFRR_BYTE_AW
) (
  input  wire logic           mclk_i,
  input  wire logic           srst_i,
  input  wire logic           cs_n_i,
  input  wire logic           sck_i,
  input  wire logic           si_i,
  output logic                so_o,
  output logic                so_oe_o,
  input  wire logic [7:0]     status_i,
  output logic                arr_rd_o,
  output logic      [PAW-1:0] arr_page_o,
  output logic      [BAW-1:0] arr_byte_o,
  input  wire logic [7:0]     arr_data_i,
  input  wire logic           buf_wr_i,
  input  wire logic           buf_sel_i,
  input  wire logic [BAW-1:0] buf_waddr_i,
  input  wire logic [7:0]     buf_wdata_i,
  output logic      [3:0]     sector_o
);

  // ==========================================================
  // Decode functions
  function automatic sfrr_pkg::sfrr_kind_e op_kind(input logic [7:0] op);
    case (op)
      `SFRR_OP_PAGE_ICP, `SFRR_OP_PAGE_SPI: op_kind = sfrr_pkg::SFRR_K_PAGE;
      `SFRR_OP_BUF1_ICP, `SFRR_OP_BUF1_SPI: op_kind = sfrr_pkg::SFRR_K_BUF1;
      `SFRR_OP_BUF2_ICP, `SFRR_OP_BUF2_SPI: op_kind = sfrr_pkg::SFRR_K_BUF2;
      `SFRR_OP_STAT_ICP, `SFRR_OP_STAT_SPI: op_kind = sfrr_pkg::SFRR_K_STAT;
      `SFRR_OP_CONT_SPI:                    op_kind = sfrr_pkg::SFRR_K_CONT;
      default:                              op_kind = sfrr_pkg::SFRR_K_NONE;
    endcase
  endfunction

  function automatic logic [3:0] sector_of(input logic [PAW-1:0] pa);
    if (pa[11:3] == 9'h000) begin
      sector_of = 4'h0;
    end else if (pa[11:8] == 4'h0) begin
      sector_of = 4'h1;
    end else if (pa[11:8] == 4'h1) begin
      sector_of = 4'h2;
    end else begin
      sector_of = {1'b0, pa[11:9]} + 4'h2;
    end
  endfunction

  // ==========================================================
  // State
  sfrr_pkg::sfrr_state_e state;
  sfrr_pkg::sfrr_kind_e  kind;
  logic [5:0]     cnt;
  logic [2:0]     bitpos;
  logic [7:0]     op_sh;
  logic [23:0]    addr_sh;
  logic [PAW-1:0] cur_page;
  logic [BAW-1:0] cur_byte;
  logic [7:0]     byte_buf;
  logic [6:0]     out_sh;
  logic           sck_q;
  logic           fetch_q;
  logic [7:0]     buf_rdata;

  // ==========================================================
  // Edge detect and phase decode
  wire                   sck_rise  = sck_i & ~sck_q & ~cs_n_i; // [R13]
  wire                   sck_fall  = ~sck_i & sck_q & ~cs_n_i;
  wire [7:0]             new_op    = {op_sh[6:0], si_i};
  wire sfrr_pkg::sfrr_kind_e new_kind = op_kind(new_op);
  wire                   op_done   = sck_rise &&
                                     state == sfrr_pkg::SFRR_IDLE &&
                                     cnt == `SFRR_OP_LAST;
  wire                   addr_done = sck_rise &&
                                     state == sfrr_pkg::SFRR_ADDR &&
                                     cnt == `SFRR_ADDR_LAST;
  wire [5:0]             dum_last  = (kind == sfrr_pkg::SFRR_K_BUF1 ||
                                      kind == sfrr_pkg::SFRR_K_BUF2) ?
                                     `SFRR_DUM_SHORT : `SFRR_DUM_LONG;
  wire                   dum_done  = sck_rise &&
                                     state == sfrr_pkg::SFRR_DUMMY &&
                                     cnt == dum_last;
  wire                   byte_start = sck_fall &&
                                      state == sfrr_pkg::SFRR_DATA &&
                                      bitpos == 3'h0;
  wire                   stat_go   = op_done &&
                                     new_kind == sfrr_pkg::SFRR_K_STAT;
  wire                   fetch     = stat_go | dum_done | byte_start;
  wire                   is_arr    = kind == sfrr_pkg::SFRR_K_CONT ||
                                     kind == sfrr_pkg::SFRR_K_PAGE;
  wire                   is_buf    = kind == sfrr_pkg::SFRR_K_BUF1 ||
                                     kind == sfrr_pkg::SFRR_K_BUF2;
  wire                   byte_wrap = cur_byte == `SFRR_BYTE_LAST;
  wire [BAW-1:0]         next_byte = byte_wrap ? '0 : cur_byte + 1'b1;
  // Only continuous read carries on into the next page
  wire [PAW-1:0]         next_page = (byte_wrap &&
                                      kind == sfrr_pkg::SFRR_K_CONT) ?
                                     cur_page + 1'b1 : cur_page; // [R8]
  wire [7:0]             next_src  = is_arr ? arr_data_i :
                                     is_buf ? buf_rdata : status_i;

  assign arr_rd_o   = fetch & is_arr;
  assign arr_page_o = cur_page;
  assign arr_byte_o = cur_byte;

  // ==========================================================
  // Buffer memory
  sfrr_bufmem #(
    .AW (BAW + 1),
    .DW (8)
  ) u_bufmem (
    .mclk_i  (mclk_i),
    .wr_i    (buf_wr_i),
    .waddr_i ({buf_sel_i, buf_waddr_i}),
    .wdata_i (buf_wdata_i),
    .rd_i    (fetch & is_buf),
    .raddr_i ({kind == sfrr_pkg::SFRR_K_BUF2, cur_byte}), // [R2] [R6]
    .rdata_o (buf_rdata)
  );

  // ==========================================================
  // Command sequencer
  always_ff @(posedge mclk_i) begin
    if (srst_i || cs_n_i) begin
      state   <= sfrr_pkg::SFRR_IDLE; // [R16]
      kind    <= sfrr_pkg::SFRR_K_NONE;
      cnt     <= '0;
      bitpos  <= '0;
      op_sh   <= '0;
      so_oe_o <= 1'b0;
    end else begin
      case (state)
        sfrr_pkg::SFRR_IDLE: begin
          if (sck_rise) begin
            op_sh <= new_op;
            cnt   <= cnt + 6'h01;
            if (op_done) begin
              cnt  <= '0;
              kind <= new_kind; // [R1] [R2] [R3] [R4] [R5] [R6] [R7]
              if (new_kind == sfrr_pkg::SFRR_K_STAT) begin
                state <= sfrr_pkg::SFRR_DATA;
              end else if (new_kind == sfrr_pkg::SFRR_K_NONE) begin
                state <= sfrr_pkg::SFRR_SKIP;
              end else begin
                state <= sfrr_pkg::SFRR_ADDR;
              end
            end
          end
        end
        sfrr_pkg::SFRR_ADDR: begin
          if (sck_rise) begin
            cnt <= addr_done ? 6'h00 : cnt + 6'h01;
            if (addr_done) begin
              state <= sfrr_pkg::SFRR_DUMMY;
            end
          end
        end
        sfrr_pkg::SFRR_DUMMY: begin
          if (sck_rise) begin
            cnt <= dum_done ? 6'h00 : cnt + 6'h01;
            if (dum_done) begin
              state <= sfrr_pkg::SFRR_DATA;
            end
          end
        end
        sfrr_pkg::SFRR_DATA: begin
          if (sck_fall) begin
            bitpos  <= bitpos + 3'h1;
            so_oe_o <= 1'b1;
          end
        end
        sfrr_pkg::SFRR_SKIP: begin
          // Unsupported opcode: idle until chip select rises
        end
        default: begin
          state <= sfrr_pkg::SFRR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Datapath
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sck_q    <= 1'b0;
      fetch_q  <= 1'b0;
      addr_sh  <= '0;
      cur_page <= '0;
      cur_byte <= '0;
      byte_buf <= '0;
      out_sh   <= '0;
      so_o     <= 1'b0;
      sector_o <= 4'h0;
    end else begin
      sck_q    <= sck_i;
      fetch_q  <= fetch;
      sector_o <= sector_of(cur_page); // [R12]
      if (sck_rise && state == sfrr_pkg::SFRR_ADDR) begin
        addr_sh <= {addr_sh[22:0], si_i}; // [R13]
      end
      // Reserved top address bits are dropped
      if (addr_done) begin
        cur_page <= new_addr_page(addr_sh, si_i);
        cur_byte <= new_addr_byte(addr_sh, si_i);
      end else if (fetch && is_arr | is_buf) begin
        cur_page <= next_page;
        cur_byte <= next_byte;
      end
      if (fetch_q) begin
        byte_buf <= next_src;
      end
      if (byte_start) begin
        so_o   <= byte_buf[7]; // [R8]
        out_sh <= byte_buf[6:0];
      end else if (sck_fall && state == sfrr_pkg::SFRR_DATA) begin
        so_o   <= out_sh[6];
        out_sh <= {out_sh[5:0], 1'b0};
      end
    end
  end

  function automatic logic [PAW-1:0] new_addr_page(input logic [23:0] a,
                                                   input logic b);
    logic [23:0] f;
    f = {a[22:0], b};
    new_addr_page = f[`SFRR_PA_LSB +: PAW];
  endfunction

  function automatic logic [BAW-1:0] new_addr_byte(input logic [23:0] a,
                                                   input logic b);
    logic [23:0] f;
    f = {a[22:0], b};
    new_addr_byte = f[`SFRR_BA_LSB +: BAW];
  endfunction

  // ==========================================================
  // Assertions
  property p_cs_release; // [R16]
    @(posedge mclk_i) disable iff (srst_i)
      cs_n_i |=> !so_oe_o && state == sfrr_pkg::SFRR_IDLE;
  endproperty
  a_cs_release: assert property (p_cs_release) // [R16]
    else $error("output still driven after chip select high");

  property p_op_52; // [R1]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && new_op == 8'h52 |=>
        kind == sfrr_pkg::SFRR_K_PAGE && state == sfrr_pkg::SFRR_ADDR;
  endproperty
  a_op_52: assert property (p_op_52) // [R1]
    else $error("52H not taken as page read");

  property p_op_buf_icp; // [R2]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && (new_op == 8'h54 || new_op == 8'h56) |=>
        kind == ($past(new_op[1]) ? sfrr_pkg::SFRR_K_BUF2 :
                                    sfrr_pkg::SFRR_K_BUF1);
  endproperty
  a_op_buf_icp: assert property (p_op_buf_icp) // [R2]
    else $error("54H/56H buffer select wrong");

  property p_op_57; // [R3]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && new_op == 8'h57 |=> state == sfrr_pkg::SFRR_DATA
        ##2 byte_buf == $past(status_i, 2);
  endproperty
  a_op_57: assert property (p_op_57) // [R3]
    else $error("57H did not load status");

  property p_op_e8; // [R4]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && new_op == 8'he8 |=> kind == sfrr_pkg::SFRR_K_CONT;
  endproperty
  a_op_e8: assert property (p_op_e8) // [R4]
    else $error("E8H not taken as continuous read");

  property p_op_d2; // [R5]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && new_op == 8'hd2 |=> kind == sfrr_pkg::SFRR_K_PAGE;
  endproperty
  a_op_d2: assert property (p_op_d2) // [R5]
    else $error("D2H not taken as page read");

  property p_op_buf_spi; // [R6]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && (new_op == 8'hd4 || new_op == 8'hd6) |=>
        state == sfrr_pkg::SFRR_ADDR && is_buf;
  endproperty
  a_op_buf_spi: assert property (p_op_buf_spi) // [R6]
    else $error("D4H/D6H not taken as buffer read");

  property p_op_d7; // [R7]
    @(posedge mclk_i) disable iff (srst_i)
      op_done && new_op == 8'hd7 |=> kind == sfrr_pkg::SFRR_K_STAT;
  endproperty
  a_op_d7: assert property (p_op_d7) // [R7]
    else $error("D7H not taken as status read");

  property p_page_cross; // [R8]
    @(posedge mclk_i) disable iff (srst_i)
      fetch && kind == sfrr_pkg::SFRR_K_CONT && byte_wrap && !cs_n_i |=>
        cur_byte == '0 && cur_page == $past(cur_page) + 1'b1;
  endproperty
  a_page_cross: assert property (p_page_cross) // [R8]
    else $error("continuous read did not cross to next page");

  property p_msb_first; // [R8]
    @(posedge mclk_i) disable iff (srst_i)
      byte_start |=> so_o == $past(byte_buf[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) // [R8]
    else $error("byte not sent MSB first");

  property p_sample_rise; // [R13]
    @(posedge mclk_i) disable iff (srst_i)
      sck_rise && state == sfrr_pkg::SFRR_ADDR |=>
        addr_sh[0] == $past(si_i);
  endproperty
  a_sample_rise: assert property (p_sample_rise) // [R13]
    else $error("serial input not sampled on rising edge");

  property p_sector; // [R12]
    @(posedge mclk_i) disable iff (srst_i)
      cur_page[11:8] == 4'h1 ##1 $stable(cur_page) |-> sector_o == 4'h2;
  endproperty
  a_sector: assert property (p_sector) // [R12]
    else $error("sector decode wrong");

endmodule

// >>> hdl/sfrr_map.svh
// Constants for the serial flash read sequencer: opcodes, phase lengths,
// page geometry and address field positions.
// Assumes inclusion by bare name from sfrr_core and the bench top module.
`ifndef SFRR_MAP_SVH
`define SFRR_MAP_SVH

// Opcodes, inactive-clock-polarity set
`define SFRR_OP_PAGE_ICP  8'h52
`define SFRR_OP_BUF1_ICP  8'h54
`define SFRR_OP_BUF2_ICP  8'h56
`define SFRR_OP_STAT_ICP  8'h57
// Opcodes, SPI mode 0 / mode 3 set
`define SFRR_OP_CONT_SPI  8'he8
`define SFRR_OP_PAGE_SPI  8'hd2
`define SFRR_OP_BUF1_SPI  8'hd4
`define SFRR_OP_BUF2_SPI  8'hd6
`define SFRR_OP_STAT_SPI  8'hd7

// Phase lengths in serial clock bits, counted from zero
`define SFRR_OP_LAST      6'h07
`define SFRR_ADDR_LAST    6'h17
`define SFRR_DUM_LONG     6'h1f
`define SFRR_DUM_SHORT    6'h07
`define SFRR_BIT_LAST     3'h7

// Page geometry: 264 bytes, last bit of a page is 2111
`define SFRR_BYTE_LAST    9'h107
`define SFRR_PAGE_AW      12
`define SFRR_BYTE_AW      9
`define SFRR_BA_LSB       0
`define SFRR_PA_LSB       9

`endif

// >>> hdl/sfrr_pkg.sv
// Types shared by the serial flash read sequencer modules.
// Assumes sfrr_map.svh is on the include path.
package sfrr_pkg;

  typedef enum logic [2:0] {
    SFRR_IDLE  = 3'h0,
    SFRR_ADDR  = 3'h1,
    SFRR_DUMMY = 3'h2,
    SFRR_DATA  = 3'h3,
    SFRR_SKIP  = 3'h4
  } sfrr_state_e;

  typedef enum logic [2:0] {
    SFRR_K_NONE = 3'h0,
    SFRR_K_CONT = 3'h1,
    SFRR_K_PAGE = 3'h2,
    SFRR_K_BUF1 = 3'h3,
    SFRR_K_BUF2 = 3'h4,
    SFRR_K_STAT = 3'h5
  } sfrr_kind_e;

endpackage

// >>> hdl/sfrr_bufmem.sv
// Two page-sized data buffers in one memory, registered read data.
// Assumes a single clock; write and read may occur in the same cycle.
module sfrr_bufmem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input  wire logic          mclk_i,
  input  wire logic          wr_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          rd_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// >>> tb/sfrr_host.sv
// Host model: drives chip select, serial clock and serial input.
// Assumes its tasks are called by the bench just after a rising mclk_i edge.
module sfrr_host (
  input  wire logic mclk_i,
  input  wire logic so_i,
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int   half    = 4;
  logic idle_hi = 1'b0;

  // ==========================================================
  // Idle levels
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  // Deselected line toggles, so no stale bit passes as data
  always @(posedge mclk_i) if (cs_n_o) si_o <= #1 ~si_o;

  // ==========================================================
  // Frame tasks
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic start(input logic mode3, input int hp);
    half    = hp;
    idle_hi = mode3;
    sck_o   = mode3;
    wait_clk(8);
    cs_n_o  = 1'b0;
    wait_clk(half);
  endtask

  // One byte each way, MSB first; si moves only while the clock is low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o  = tx[i];
      wait_clk(half);
      rx[i] = so_i;
      sck_o = 1'b1;
      wait_clk(half);
    end
  endtask

  task automatic stop();
    sck_o  = idle_hi;
    wait_clk(half);
    cs_n_o = 1'b1;
    wait_clk(32);
  endtask
endmodule

// >>> tb/sfrr_core_tb_top.sv
// Self-checking bench of the read sequencer with a host model.
// Assumes sfrr_map.svh on the include path and sfrr_pkg compiled.
`include "sfrr_map.svh"

module sfrr_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        cs_n_i;
  logic        sck_i;
  logic        si_i;
  logic        so_o;
  logic        so_oe_o;
  // Released line shows the inverse of the last bit
  wire         so_line = so_oe_o ? so_o : ~so_o;
  logic [7:0]  status_i = 8'h00;
  logic        arr_rd_o;
  logic [11:0] arr_page_o;
  logic [8:0]  arr_byte_o;
  logic [7:0]  arr_data_i = 8'h00;
  logic        buf_wr_i = 1'b0;
  logic        buf_sel_i = 1'b0;
  logic [8:0]  buf_waddr_i = 9'h000;
  logic [7:0]  buf_wdata_i = 8'h00;
  logic [3:0]  sector_o;
  logic [31:0] seed = 32'h29c33a46;
  int          n_errors = 0;
  int          checks = 0;

  sfrr_core sfrr_core_i (.mclk_i(mclk_i), .srst_i(srst_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .status_i(status_i), .arr_rd_o(arr_rd_o),
    .arr_page_o(arr_page_o), .arr_byte_o(arr_byte_o),
    .arr_data_i(arr_data_i), .buf_wr_i(buf_wr_i), .buf_sel_i(buf_sel_i),
    .buf_waddr_i(buf_waddr_i), .buf_wdata_i(buf_wdata_i),
    .sector_o(sector_o));

  sfrr_host sfrr_host_i (.mclk_i(mclk_i), .so_i(so_line), .cs_n_o(cs_n_i),
    .sck_o(sck_i), .si_o(si_i));

  initial forever #4 mclk_i = ~mclk_i;

  // ==========================================================
  // Expectation functions
  function automatic logic [7:0] arr_val(input logic [11:0] p,
                                         input logic [8:0]  b);
    return (p[7:0] ^ {p[11:8], 4'h3}) + b[7:0] + {7'h00, b[8]};
  endfunction
  function automatic logic [7:0] buf_val(input logic s, input logic [8:0] b);
    return {s, b[6:0]} ^ {b[8:7], 6'h15};
  endfunction
  function automatic logic [3:0] exp_sector(input logic [11:0] p);
    if (p[11:3] == 9'h000) return 4'h0;
    if (p[11:8] == 4'h0) return 4'h1;
    if (p[11:8] == 4'h1) return 4'h2;
    return {1'b0, p[11:9]} + 4'h2;
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Array answers the cycle after each read strobe
  always @(posedge mclk_i) begin
    if (arr_rd_o) arr_data_i <= arr_val(arr_page_o, arr_byte_o);
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #800000;
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    final_report();
  end

  task automatic rnd();
    seed = lfsr(seed);
  endtask

  // ==========================================================
  // One read command with nb data bytes compared on the fly
  task automatic run(input logic [7:0] op, input sfrr_pkg::sfrr_kind_e k,
                     input logic [11:0] pg, input logic [8:0] by,
                     input int nb, input logic m3);
    logic [7:0]  rx;
    logic [11:0] p;
    logic [8:0]  b;
    logic [23:0] ad;
    p = pg;
    b = by;
    ad = {3'h0, pg, by};
    rnd();
    status_i = seed[7:0];
    sfrr_host_i.start(m3, seed[8] ? 6 : 3);
    sfrr_host_i.xfer(op, rx);
    if (k != sfrr_pkg::SFRR_K_STAT) begin
      for (int i = 2; i >= 0; i--) sfrr_host_i.xfer(ad[8*i +: 8], rx);
      for (int i = 0; i < ((k == sfrr_pkg::SFRR_K_BUF1 ||
                            k == sfrr_pkg::SFRR_K_BUF2) ? 1 : 4); i++) begin
        rnd();
        sfrr_host_i.xfer(seed[7:0], rx);
      end
    end
    for (int i = 0; i < nb; i++) begin
      rnd();
      sfrr_host_i.xfer(seed[7:0], rx);
      case (k)
        sfrr_pkg::SFRR_K_STAT: check(rx, status_i, "status");
        sfrr_pkg::SFRR_K_BUF1: check(rx, buf_val(1'b0, b), "buf1");
        sfrr_pkg::SFRR_K_BUF2: check(rx, buf_val(1'b1, b), "buf2");
        default: check(rx, arr_val(p, b), "array");
      endcase
      check({7'h00, so_oe_o}, 8'h01, "drive on");
      if (b == `SFRR_BYTE_LAST) begin
        b = 9'h000;
        if (k == sfrr_pkg::SFRR_K_CONT) p = p + 12'h001;
      end
      else b = b + 9'h001;
    end
    if (k == sfrr_pkg::SFRR_K_PAGE) begin
      check({4'h0, sector_o}, {4'h0, exp_sector(pg)}, "sector");
    end
    sfrr_host_i.stop();
    check({7'h00, so_oe_o}, 8'h00, "drive off");
  endtask

  // ==========================================================
  // Main sequence
  logic [7:0]           ops [9];
  sfrr_pkg::sfrr_kind_e kinds [9];
  logic [11:0]          corners [14];
  logic [11:0]          refresh_ptr;
  logic [7:0]           rx;
  initial begin
    ops = '{`SFRR_OP_PAGE_ICP, `SFRR_OP_BUF1_ICP, `SFRR_OP_BUF2_ICP,
            `SFRR_OP_STAT_ICP, `SFRR_OP_CONT_SPI, `SFRR_OP_PAGE_SPI,
            `SFRR_OP_BUF1_SPI, `SFRR_OP_BUF2_SPI, `SFRR_OP_STAT_SPI};
    kinds = '{sfrr_pkg::SFRR_K_PAGE, sfrr_pkg::SFRR_K_BUF1,
              sfrr_pkg::SFRR_K_BUF2, sfrr_pkg::SFRR_K_STAT,
              sfrr_pkg::SFRR_K_CONT, sfrr_pkg::SFRR_K_PAGE,
              sfrr_pkg::SFRR_K_BUF1, sfrr_pkg::SFRR_K_BUF2,
              sfrr_pkg::SFRR_K_STAT};
    corners = '{12'h000, 12'h007, 12'h008, 12'h0ff, 12'h100, 12'h1ff,
                12'h200, 12'h3ff, 12'h400, 12'h7ff, 12'h800, 12'hbff,
                12'hc00, 12'hfff};
    repeat (5) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    check({7'h00, so_oe_o}, 8'h00, "reset drive");
    check({4'h0, sector_o}, 8'h00, "reset sector");
    for (int s = 0; s < 2; s++) begin
      for (int a = 0; a <= `SFRR_BYTE_LAST; a++) begin
        buf_wr_i    = 1'b1;
        buf_sel_i   = s[0];
        buf_waddr_i = a[8:0];
        buf_wdata_i = buf_val(s[0], a[8:0]);
        sfrr_host_i.wait_clk(1);
      end
    end
    buf_wr_i = 1'b0;
    // Every opcode, wrap at the page end, both clock idle levels
    for (int i = 0; i < 9; i++) begin
      run(ops[i], kinds[i], 12'hfff, 9'h106, 3, i[0]);
    end
    foreach (corners[i]) begin
      run(ops[5 * i[0]], sfrr_pkg::SFRR_K_PAGE, corners[i], 9'h000,
          1, i[1]);
    end
    repeat (12) begin
      rnd();
      run(ops[seed[3:0] % 9], kinds[seed[3:0] % 9], seed[27:16],
          seed[31:28] == 4'h0 ? 9'h107 : {1'b0, seed[15:8]}, 2, seed[5]);
    end
    // Unsupported opcodes keep the output released
    sfrr_host_i.start(1'b0, 4);
    sfrr_host_i.xfer(8'h68, rx);
    repeat (5) begin
      sfrr_host_i.xfer(8'h00, rx);
      check({7'h00, so_oe_o}, 8'h00, "unknown opcode");
    end
    sfrr_host_i.stop();
    // Abort inside the address, then a fresh command
    sfrr_host_i.start(1'b1, 3);
    sfrr_host_i.xfer(`SFRR_OP_PAGE_SPI, rx);
    sfrr_host_i.xfer(8'h01, rx);
    sfrr_host_i.stop();
    check({7'h00, so_oe_o}, 8'h00, "abort");
    run(`SFRR_OP_STAT_SPI, sfrr_pkg::SFRR_K_STAT, 12'h000, 9'h000,
        2, 1'b0);
    // Pages of sector 0 and the first of sector 1, led by a refresh pointer
    refresh_ptr = 12'h000;
    repeat (9) begin
      run(`SFRR_OP_PAGE_SPI, sfrr_pkg::SFRR_K_PAGE, refresh_ptr,
          9'h000, 1, refresh_ptr[0]);
      refresh_ptr = refresh_ptr + 12'h001;
    end
    final_report();
  end
endmodule
